// ==== core/eic_consts.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef EIC_CONSTS_SVH
`define EIC_CONSTS_SVH

`define EIC_ADDR_W         8
`define EIC_A_CNT_IC       8'h00
`define EIC_A_FILT0        8'h04
`define EIC_A_FILT1        8'h08
`define EIC_A_EN0          8'h0C
`define EIC_A_EN1          8'h10
`define EIC_A_ROUTE        8'h14
`define EIC_A_TMR_IC       8'h18
`define EIC_A_TMR_CTL      8'h1C
`define EIC_A_GATE_IC      8'h20
`define EIC_A_STATUS       8'h24
`define EIC_A_MASK         8'h28
`define EIC_A_COUNT        8'h2C

`define EIC_LVL_LO         0
`define EIC_LVL_HI         2
`define EIC_REQ            3
`define EIC_POL            4
`define EIC_GFILT_LO       4
`define EIC_GFILT_HI       5
`define EIC_CFILT_LO       0
`define EIC_CFILT_HI       1
`define EIC_GON            4
`define EIC_GBOTH          5
`define EIC_CON            0
`define EIC_CBOTH          1
`define EIC_ROUTE_LO       0
`define EIC_ROUTE_HI       1
`define EIC_ROUTE_CNT      2'b10
`define EIC_RUN            0
`define EIC_RUNNING        1

`define EIC_WM_IC          8'h1F
`define EIC_WM_TMR_IC      8'h0F
`define EIC_WM_FILT0       8'h30
`define EIC_WM_LO2         8'h03
`define EIC_WM_EN0         8'h30
`define EIC_WM_RUN         8'h01
`define EIC_WM_EV          3'h7

`define EIC_RST_REG        8'h00
`define EIC_RST_EV         3'h0
`define EIC_RST_CNT        16'h0000
`define EIC_CNT_MAX        16'hFFFF

`define EIC_EV_CNT         0
`define EIC_EV_GATE        1
`define EIC_EV_TMR         2

`define EIC_FILT_OFF       2'b00
`define EIC_FILT_MATCH     2'd2
`define EIC_DIV_W          5
`define EIC_DIV_MED_MSK    5'h07
`define EIC_DIV_SLOW_MSK   5'h1F

`endif

// ==== core/eic_edge_det.sv ====
// Noise filter and edge detector for one external input pin
`timescale 1ns/1ps
module eic_edge_det
   import eic_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       pin,
   input  wire logic [1:0] filt_sel,
   input  wire logic [2:0] tick,
   input  wire logic       on,
   input  wire logic       both,
   input  wire logic       edge_direction_bit,
   output logic            level,
   output logic            edge_pulse
);
`include "eic_consts.svh"

   eic_edge_state_t s_reg;
   eic_edge_state_t s_next;
   logic            smp_en;
   logic            rise;
   logic            fall;

   always_comb begin
      s_next = s_reg;
      smp_en = 1'b0;
      case (filt_sel)
         2'b01:   smp_en = tick[0];
         2'b10:   smp_en = tick[1];
         2'b11:   smp_en = tick[2];
         default: smp_en = 1'b0;
      endcase
      // Four equal samples in a row before the level moves
      if (smp_en) begin
         if (pin == s_reg.samp) begin
            if (s_reg.match == `EIC_FILT_MATCH) begin
               s_next.filt = pin;
            end else begin
               s_next.match = s_reg.match + 2'd1;
            end
         end else begin
            s_next.samp  = pin;
            s_next.match = 2'd0;
         end
      end
      level = (filt_sel == `EIC_FILT_OFF) ? pin : s_reg.filt;
      s_next.prev = level;
      rise = level & ~s_reg.prev;
      fall = ~level & s_reg.prev;
      if (!on) begin
         edge_pulse = 1'b0;
      end else if (both) begin
         edge_pulse = rise | fall;
      end else begin
         edge_pulse = edge_direction_bit ? rise : fall;
      end
   end

   // Idle high so that release of reset does not look like an edge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_reg <= '{samp: 1'b1, match: 2'd0, filt: 1'b1, prev: 1'b1};
      end else begin
         s_reg <= s_next;
      end
   end

endmodule

// ==== core/eic_pkg.sv ====
// Types shared by the external event input block
package eic_pkg;

   typedef struct packed {
      logic       samp;
      logic [1:0] match;
      logic       filt;
      logic       prev;
   } eic_edge_state_t;

   typedef struct packed {
      logic [7:0]  cnt_ic;
      logic [7:0]  gate_ic;
      logic [7:0]  tmr_ic;
      logic [7:0]  filt0;
      logic [7:0]  filt1;
      logic [7:0]  en0;
      logic [7:0]  en1;
      logic [7:0]  route;
      logic [7:0]  tmr_ctl;
      logic        running;
      logic [2:0]  status;
      logic [2:0]  mask;
      logic [15:0] count;
      logic [4:0]  div;
      logic [31:0] rdata;
      logic        irq;
   } eic_state_t;

endpackage

// ==== core/eic_top.sv ====
// External event inputs, interrupt control and gated event counting
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "eic_consts.svh"
// Contract
// - Control registers hold a 3-bit level in b2..b0; zero blocks the source.
// - Bit b3 is the request flag, set by the event, cleared by writing zero.
// - Count input control bit b4 picks polarity; zero means falling edge.
// - Gating filter select at filter register 0 b5..b4; 00 passes pin directly.
// - Count filter select at filter register 1 b1..b0; 00 bypasses the filter.
// - Enable register 0 b5 picks gating detection; zero means one edge by polarity.
// - Enable register 0 b4 enables gating input toward interrupt and timer gating.
// - Enable register 1 b1 set detects both edges of the count input.
// - Enable register 1 b0 enables the count input; edges then pass onward.
// - Route select b1..b0 code 10 feeds the timer from the count input pin.
// - Timer control register accepts level zero and cleared flag in b3..b0.
// - Timer control b0 starts counting when one, stops when zero.
// - Timer control b1 reads whether counting really runs.
module eic_top
   import eic_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   input  wire logic [`EIC_ADDR_W-1:0] paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   gating_input,
   input  wire logic                   count_source_input,
   input  wire logic                   timer_io_pin,
   output logic                        irq,
   output logic                        count_running_flag
);

   // Whole block state; one next-state copy per cycle
   eic_state_t s_reg;
   eic_state_t s_next;

   logic [2:0] tick;
   logic       gate_level;
   logic       gate_edge;
   logic       cnt_edge;
   logic       tio_edge;
   logic       timer_event;
   logic       gate_open;
   logic       count_step;
   logic       wrap;
   logic       wr_access;
   logic       setup;
   logic       mapped;
   logic [2:0] ev_vec;
   logic [2:0] w1c;
   logic [2:0] lvl_nz;
   logic [31:0] rd_mux;
   logic       we_cnt_ic;
   logic       we_gate_ic;
   logic       we_tmr_ic;
   logic       we_filt0;
   logic       we_filt1;
   logic       we_en0;
   logic       we_en1;
   logic       we_route;
   logic       we_tmr_ctl;
   logic       we_mask;
   logic       we_status;

   // Control register write: request flag may only be cleared by software
   function automatic logic [7:0] ic_upd(
      input logic [7:0] old,
      input logic [7:0] wdata,
      input logic       wr,
      input logic       ev,
      input logic [7:0] msk
   );
      logic [7:0] v;
      v = old;
      if (wr) begin
         v = wdata & msk;
         v[`EIC_REQ] = old[`EIC_REQ] & wdata[`EIC_REQ];
      end
      if (ev) begin
         v[`EIC_REQ] = 1'b1;
      end
      return v;
   endfunction

   // Level zero keeps the source off the interrupt
   function automatic logic lvl_on(input logic [7:0] ic);
      return ic[`EIC_LVL_HI:`EIC_LVL_LO] != 3'b000;
   endfunction

   // Plain write; reserved bits read back as zero
   function automatic logic [7:0] reg_wr(
      input logic [7:0] old,
      input logic [7:0] wdata,
      input logic       wr,
      input logic [7:0] msk
   );
      return wr ? (wdata & msk) : old;
   endfunction

   // Sample enables for the three filter rates
   assign tick[0] = 1'b1;
   assign tick[1] = (s_reg.div & `EIC_DIV_MED_MSK) == '0;
   assign tick[2] = (s_reg.div & `EIC_DIV_SLOW_MSK) == '0;

   eic_edge_det u_gate (
      .core_clk   (core_clk),
      .rst        (rst),
      .pin        (gating_input),
      .filt_sel   (s_reg.filt0[`EIC_GFILT_HI:`EIC_GFILT_LO]),
      .tick       (tick),
      .on         (s_reg.en0[`EIC_GON]),
      .both       (s_reg.en0[`EIC_GBOTH]),
      .edge_direction_bit        (s_reg.gate_ic[`EIC_POL]),
      .level      (gate_level),
      .edge_pulse (gate_edge)
   );

   // Count input also clocks the timer when routed
   eic_edge_det u_count (
      .core_clk   (core_clk),
      .rst        (rst),
      .pin        (count_source_input),
      .filt_sel   (s_reg.filt1[`EIC_CFILT_HI:`EIC_CFILT_LO]),
      .tick       (tick),
      .on         (s_reg.en1[`EIC_CON]),
      .both       (s_reg.en1[`EIC_CBOTH]),
      .edge_direction_bit        (s_reg.cnt_ic[`EIC_POL]),
      .level      (),
      .edge_pulse (cnt_edge)
   );

   // Dedicated timer pin: unfiltered, falling edge, live only while counting
   eic_edge_det u_tio (
      .core_clk   (core_clk),
      .rst        (rst),
      .pin        (timer_io_pin),
      .filt_sel   (`EIC_FILT_OFF),
      .tick       (tick),
      .on         (s_reg.running),
      .both       (1'b0),
      .edge_direction_bit        (1'b0),
      .level      (),
      .edge_pulse (tio_edge)
   );

   always_comb begin
      // Routing picks which pin clocks the counter
      if (s_reg.route[`EIC_ROUTE_HI:`EIC_ROUTE_LO] == `EIC_ROUTE_CNT) begin
         timer_event = cnt_edge;
      end else begin
         timer_event = tio_edge;
      end
      // Disabled gating input closes the gate rather than leaving it open
      gate_open  = s_reg.en0[`EIC_GON] & gate_level;
      count_step = s_reg.running & gate_open & timer_event;
      wrap       = count_step & (s_reg.count == `EIC_CNT_MAX);
   end

   // Read data latched in setup so the access phase needs no wait
   always_comb begin
      setup     = psel & ~penable;
      wr_access = psel & penable & pwrite;
      mapped    = 1'b1;
      rd_mux    = '0;
      case (paddr)
         `EIC_A_CNT_IC:  rd_mux[7:0] = s_reg.cnt_ic;
         `EIC_A_GATE_IC: rd_mux[7:0] = s_reg.gate_ic;
         `EIC_A_TMR_IC:  rd_mux[7:0] = s_reg.tmr_ic;
         `EIC_A_FILT0:   rd_mux[7:0] = s_reg.filt0;
         `EIC_A_FILT1:   rd_mux[7:0] = s_reg.filt1;
         `EIC_A_EN0:     rd_mux[7:0] = s_reg.en0;
         `EIC_A_EN1:     rd_mux[7:0] = s_reg.en1;
         `EIC_A_ROUTE:   rd_mux[7:0] = s_reg.route;
         `EIC_A_TMR_CTL: begin
            rd_mux[7:0] = s_reg.tmr_ctl;
            rd_mux[`EIC_RUNNING] = s_reg.running;
         end
         `EIC_A_STATUS:  rd_mux[2:0] = s_reg.status;
         `EIC_A_MASK:    rd_mux[2:0] = s_reg.mask;
         `EIC_A_COUNT:   rd_mux[15:0] = s_reg.count;
         default:        mapped = 1'b0;
      endcase
   end

   // One write strobe per register, decoded once
   always_comb begin
      we_cnt_ic  = wr_access && paddr == `EIC_A_CNT_IC;
      we_gate_ic = wr_access && paddr == `EIC_A_GATE_IC;
      we_tmr_ic  = wr_access && paddr == `EIC_A_TMR_IC;
      we_filt0   = wr_access && paddr == `EIC_A_FILT0;
      we_filt1   = wr_access && paddr == `EIC_A_FILT1;
      we_en0     = wr_access && paddr == `EIC_A_EN0;
      we_en1     = wr_access && paddr == `EIC_A_EN1;
      we_route   = wr_access && paddr == `EIC_A_ROUTE;
      we_tmr_ctl = wr_access && paddr == `EIC_A_TMR_CTL;
      we_mask    = wr_access && paddr == `EIC_A_MASK;
      we_status  = wr_access && paddr == `EIC_A_STATUS;
   end

   // Event, clear and level vectors share one bit order
   always_comb begin
      ev_vec = '0;
      ev_vec[`EIC_EV_CNT]  = cnt_edge;
      ev_vec[`EIC_EV_GATE] = gate_edge;
      ev_vec[`EIC_EV_TMR]  = wrap;
      w1c = '0;
      if (we_status) begin
         w1c = pwdata[2:0];
      end
      lvl_nz = '0;
      lvl_nz[`EIC_EV_CNT]  = lvl_on(s_reg.cnt_ic);
      lvl_nz[`EIC_EV_GATE] = lvl_on(s_reg.gate_ic);
      lvl_nz[`EIC_EV_TMR]  = lvl_on(s_reg.tmr_ic);
   end

   always_comb begin
      s_next = s_reg;
      s_next.div = s_reg.div + `EIC_DIV_W'(1);

      // Request flags: an event beats a clearing write
      s_next.cnt_ic = ic_upd(s_reg.cnt_ic, pwdata[7:0],
                             we_cnt_ic,
                             cnt_edge, `EIC_WM_IC);
      s_next.gate_ic = ic_upd(s_reg.gate_ic, pwdata[7:0],
                              we_gate_ic,
                              gate_edge, `EIC_WM_IC);
      s_next.tmr_ic = ic_upd(s_reg.tmr_ic, pwdata[7:0],
                             we_tmr_ic,
                             wrap, `EIC_WM_TMR_IC);

      // Configuration registers keep only their defined bits
      s_next.filt0 = reg_wr(s_reg.filt0, pwdata[7:0],
                            we_filt0, `EIC_WM_FILT0);
      s_next.filt1 = reg_wr(s_reg.filt1, pwdata[7:0],
                            we_filt1, `EIC_WM_LO2);
      s_next.en0 = reg_wr(s_reg.en0, pwdata[7:0],
                          we_en0, `EIC_WM_EN0);
      s_next.en1 = reg_wr(s_reg.en1, pwdata[7:0],
                          we_en1, `EIC_WM_LO2);
      s_next.route = reg_wr(s_reg.route, pwdata[7:0],
                            we_route, `EIC_WM_LO2);
      s_next.tmr_ctl = reg_wr(s_reg.tmr_ctl, pwdata[7:0],
                              we_tmr_ctl, `EIC_WM_RUN);
      if (we_mask) begin
         s_next.mask = pwdata[2:0] & `EIC_WM_EV;
      end

      // Running flag trails the start bit by one cycle so software can poll a stop
      s_next.running = s_reg.tmr_ctl[`EIC_RUN];
      // Counter rolls over; only the wrap raises the timer request
      if (count_step) begin
         s_next.count = s_reg.count + 16'h0001;
      end

      // Set wins over a same-cycle clear
      s_next.status = (s_reg.status & ~w1c) | ev_vec;
      s_next.irq = |(s_next.status & s_reg.mask & lvl_nz);

      if (setup) begin
         s_next.rdata = rd_mux;
      end
   end

   // Async reset returns every field to zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_reg <= '{cnt_ic:  `EIC_RST_REG,
                    gate_ic: `EIC_RST_REG,
                    tmr_ic:  `EIC_RST_REG,
                    filt0:   `EIC_RST_REG,
                    filt1:   `EIC_RST_REG,
                    en0:     `EIC_RST_REG,
                    en1:     `EIC_RST_REG,
                    route:   `EIC_RST_REG,
                    tmr_ctl: `EIC_RST_REG,
                    running: 1'b0,
                    status:  `EIC_RST_EV,
                    mask:    `EIC_RST_EV,
                    count:   `EIC_RST_CNT,
                    div:     '0,
                    rdata:   '0,
                    irq:     1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // Zero wait states; read data was captured in the setup cycle
   assign pready             = 1'b1;
   assign pslverr            = psel & penable & ~mapped;
   assign prdata             = s_reg.rdata;
   assign irq                = s_reg.irq;
   assign count_running_flag = s_reg.running;

endmodule

// ==== test/eic_pulse_src.sv ====
// Behavioural pulse source for the gate, count and timer pins
`timescale 1ns/1ps
module eic_pulse_src (
   input  wire logic core_clk,
   output logic      gating_input,
   output logic      count_source_input,
   output logic      timer_io_pin
);
   // Pins idle high so no stray edge appears at enable
   initial begin
      gating_input = 1'b1;
      count_source_input = 1'b1;
      timer_io_pin = 1'b1;
   end
   task automatic gate(input logic v);
      @(posedge core_clk);
      gating_input <= v;
   endtask
   // Gap of one cycle gives the narrowest glitch
   task automatic toggle(input int n, input int gap);
      repeat (n) begin
         repeat (gap) @(posedge core_clk);
         count_source_input <= ~count_source_input;
      end
   endtask
   task automatic tio_pulse(input int n);
      repeat (n) begin
         @(posedge core_clk);
         timer_io_pin <= 1'b0;
         repeat (2) @(posedge core_clk);
         timer_io_pin <= 1'b1;
      end
   endtask
endmodule

// ==== test/eic_top_assertions.sv ====
// Port-level assertions for the external event input block
`timescale 1ns/1ps
`include "eic_consts.svh"
module eic_top_assertions
   import eic_pkg::*;
(
   input wire logic                   core_clk,
   input wire logic                   rst,
   input wire logic [`EIC_ADDR_W-1:0] paddr,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic                   gating_input,
   input wire logic                   count_source_input,
   input wire logic                   timer_io_pin,
   input wire logic                   irq,
   input wire logic                   count_running_flag
);
   logic       acc, wr_acc, rd_acc, mapped, quiet, pol_sh;
   logic [2:0] mask_sh, lvl_c, lvl_g, lvl_t;
   logic [1:0] en1_sh, filt1_sh;
   assign acc = psel && penable && pready;
   assign wr_acc = acc && pwrite;
   assign rd_acc = acc && !pwrite;
   assign mapped = paddr[1:0] == 2'b00 && paddr <= `EIC_A_COUNT;
   assign quiet = !(mask_sh[0] && lvl_c != 3'h0) && !(mask_sh[1] && lvl_g != 3'h0)
                  && !(mask_sh[2] && lvl_t != 3'h0);
   // Shadow of the configuration that decides whether an edge may interrupt
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         {mask_sh, lvl_c, lvl_g, lvl_t, en1_sh, filt1_sh, pol_sh} <= 17'h0_0000;
      end else if (wr_acc) begin
         case (paddr)
            `EIC_A_CNT_IC: {pol_sh, lvl_c} <= {pwdata[4], pwdata[2:0]};
            `EIC_A_GATE_IC: lvl_g <= pwdata[2:0];
            `EIC_A_TMR_IC: lvl_t <= pwdata[2:0];
            `EIC_A_EN1: en1_sh <= pwdata[1:0];
            `EIC_A_FILT1: filt1_sh <= pwdata[1:0];
            `EIC_A_MASK: mask_sh <= pwdata[2:0];
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_ctl_wr; wr_acc && paddr == `EIC_A_TMR_CTL; endsequence
   sequence s_edge;
      en1_sh[0] && filt1_sh == 2'b00 && (en1_sh[1] ? $changed(count_source_input) :
         (pol_sh ? $rose(count_source_input) : $fell(count_source_input)));
   endsequence
   sequence s_armed; mask_sh[0] && lvl_c != 3'h0; endsequence
   property p_ready; psel && penable |-> pready; endproperty
   property p_unmapped; acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0000_0000); endproperty
   property p_mapped; acc && mapped |-> !pslverr; endproperty
   property p_run; s_ctl_wr |-> ##2 count_running_flag == $past(pwdata[`EIC_RUN], 2); endproperty
   property p_runrd;
      rd_acc && paddr == `EIC_A_TMR_CTL |-> prdata[`EIC_RUNNING] == $past(count_running_flag);
   endproperty
   property p_hit; s_edge ##0 s_armed |=> irq; endproperty
   property p_quiet; quiet && $past(quiet) |-> !irq; endproperty
   property p_tmr_ic; rd_acc && paddr == `EIC_A_TMR_IC |-> prdata[31:4] == 28'h000_0000; endproperty
   a_ready: assert property (p_ready) else $error("pready low in access phase");
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   a_mapped: assert property (p_mapped) else $error("error on mapped access");
   a_run: assert property (p_run) else $error("running flag does not follow run bit");
   a_runrd: assert property (p_runrd) else $error("running flag read back wrong");
   a_hit: assert property (p_hit) else $error("armed edge gave no interrupt");
   a_quiet: assert property (p_quiet) else $error("interrupt while no source armed");
   a_tmr_ic: assert property (p_tmr_ic) else $error("timer control upper bits not zero");
endmodule
bind eic_top eic_top_assertions chk_u (.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
   .prdata, .pready, .pslverr, .gating_input, .count_source_input, .timer_io_pin, .irq, .count_running_flag);

// ==== test/ext_event_input_config_tb.sv ====
// Register, event and counting tests for the external event input block
`timescale 1ns/1ps
`include "eic_consts.svh"
`define CK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module ext_event_input_config_tb;
   import eic_pkg::*;
   logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, irq, count_running_flag, err;
   logic        gating_input, count_source_input, timer_io_pin;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdat;
   int          n_fail = 0;
   int          comparisons = 0;
   logic [7:0]  adr [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h28};
   logic [7:0]  msk [9] = '{8'h17, 8'h30, 8'h03, 8'h30, 8'h03, 8'h03, 8'h07, 8'h17, 8'h07};
   eic_top dut_u (.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .gating_input, .count_source_input, .timer_io_pin, .irq, .count_running_flag);
   eic_pulse_src src_u (.core_clk, .gating_input, .count_source_input, .timer_io_pin);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(a, 1'b1, d); endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0000_0000);
      `CK(rdat, e)
   endtask
   task automatic idle(input int n); repeat (n) @(posedge core_clk); endtask
   task automatic close_out;
      $display("mismatches %0d of %0d comparisons", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (6000) @(posedge core_clk);
      n_fail++;
      close_out();
   end
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {4'b1000, 8'h00, 32'h0000_0000};
      idle(2);
      rst <= 1'b0;
      for (int i = 0; i < 12; i++) chk(8'(i * 4), 32'h0000_0000);
      chk(8'h30, 32'h0000_0000);
      `CK(err, 1'b1)
      foreach (adr[i]) begin
         wr(adr[i], 32'hFFFF_FFFF);
         chk(adr[i], {24'h00_0000, msk[i]});
         wr(adr[i], 32'h0000_0000);
      end
      $display("register test done");
      wr(`EIC_A_CNT_IC, 32'h0000_0001);
      wr(`EIC_A_EN1, 32'h0000_0001);
      wr(`EIC_A_MASK, 32'h0000_0001);
      src_u.toggle(1, 1);
      idle(2);
      chk(`EIC_A_CNT_IC, 32'h0000_0009);
      `CK(irq, 1'b1)
      src_u.toggle(1, 1);
      wr(`EIC_A_STATUS, 32'h0000_0001);
      wr(`EIC_A_CNT_IC, 32'h0000_0001);
      idle(2);
      chk(`EIC_A_CNT_IC, 32'h0000_0001);
      `CK(irq, 1'b0)
      wr(`EIC_A_CNT_IC, 32'h0000_0011);
      src_u.toggle(2, 2);
      idle(2);
      chk(`EIC_A_CNT_IC, 32'h0000_0019);
      wr(`EIC_A_CNT_IC, 32'h0000_0010);
      wr(`EIC_A_STATUS, 32'h0000_0001);
      src_u.toggle(2, 2);
      idle(2);
      `CK(irq, 1'b0)
      chk(`EIC_A_STATUS, 32'h0000_0001);
      wr(`EIC_A_STATUS, 32'h0000_0001);
      wr(`EIC_A_CNT_IC, 32'h0000_0001);
      wr(`EIC_A_EN1, 32'h0000_0000);
      src_u.toggle(1, 1);
      idle(2);
      chk(`EIC_A_STATUS, 32'h0000_0000);
      wr(`EIC_A_EN1, 32'h0000_0003);
      src_u.toggle(1, 1);
      idle(2);
      chk(`EIC_A_STATUS, 32'h0000_0001);
      wr(`EIC_A_STATUS, 32'h0000_0001);
      wr(`EIC_A_FILT1, 32'h0000_0001);
      src_u.toggle(2, 1);
      idle(4);
      chk(`EIC_A_STATUS, 32'h0000_0000);
      wr(`EIC_A_FILT1, 32'h0000_0000);
      src_u.toggle(2, 1);
      idle(2);
      chk(`EIC_A_STATUS, 32'h0000_0001);
      $display("edge test done");
      wr(`EIC_A_ROUTE, 32'h0000_0002);
      wr(`EIC_A_EN0, 32'h0000_0010);
      wr(`EIC_A_TMR_CTL, 32'h0000_0001);
      idle(2);
      chk(`EIC_A_TMR_CTL, 32'h0000_0003);
      `CK(count_running_flag, 1'b1)
      src_u.toggle(6, 2);
      idle(3);
      chk(`EIC_A_COUNT, 32'h0000_0006);
      src_u.gate(1'b0);
      src_u.toggle(4, 2);
      src_u.gate(1'b1);
      idle(3);
      chk(`EIC_A_COUNT, 32'h0000_0006);
      wr(`EIC_A_EN0, 32'h0000_0000);
      src_u.toggle(2, 2);
      idle(3);
      chk(`EIC_A_COUNT, 32'h0000_0006);
      wr(`EIC_A_EN0, 32'h0000_0010);
      wr(`EIC_A_ROUTE, 32'h0000_0000);
      src_u.tio_pulse(3);
      src_u.toggle(2, 2);
      idle(3);
      chk(`EIC_A_COUNT, 32'h0000_0009);
      wr(`EIC_A_TMR_CTL, 32'h0000_0000);
      idle(2);
      chk(`EIC_A_TMR_CTL, 32'h0000_0000);
      `CK(count_running_flag, 1'b0)
      src_u.tio_pulse(2);
      idle(3);
      chk(`EIC_A_COUNT, 32'h0000_0009);
      $display("count test done");
      wr(`EIC_A_GATE_IC, 32'h0000_0001);
      wr(`EIC_A_STATUS, 32'h0000_0007);
      wr(`EIC_A_FILT0, 32'h0000_0010);
      src_u.gate(1'b0);
      src_u.gate(1'b1);
      idle(4);
      chk(`EIC_A_STATUS, 32'h0000_0000);
      wr(`EIC_A_FILT0, 32'h0000_0000);
      src_u.gate(1'b0);
      src_u.gate(1'b1);
      idle(2);
      chk(`EIC_A_STATUS, 32'h0000_0002);
      `CK(irq, 1'b0)
      wr(`EIC_A_MASK, 32'h0000_0002);
      idle(2);
      `CK(irq, 1'b1)
      wr(`EIC_A_STATUS, 32'h0000_0002);
      idle(2);
      `CK(irq, 1'b0)
      $display("gate test done");
      close_out();
   end
endmodule
